// *** design/humidity_temp_sensor_regs.v ***
// I2C target and register file of the humidity and temperature sensor
//
// Overview of operation
// - Read returns high byte then low, pointer advances
// - Reserved bits written zero, read undefined
// - Status bit 0 high while converting
// - High data register holds result MSBs, read-only
// - Low data register holds result LSBs, read-only
// - Fast bit selects 18ms or 35ms conversion
// - Temp bit selects temperature or humidity measurement
// - Heater_on bit switches the heater on or off
// - Writing start bit launches a conversion unless one is running
// - Identification: fixed upper nibble, lower nibble zero
`timescale 1ns/1ns
`include "sensor_regs_consts.vh"

module humidity_temp_sensor_regs #(
  parameter [19:0] CONV_NORMAL_CYCLES = `CONV_NORMAL_CYCLES,
  parameter [19:0] CONV_FAST_CYCLES   = `CONV_FAST_CYCLES,
  // Arbitrary part code, not tied to any real device
  parameter [3:0]  PART_CODE          = 4'ha
) (
  input  wire        CLK,
  input  wire        RESET_N,
  input  wire        SCL,
  input  wire        SDA_IN,
  output reg         SDA_OUT,
  output reg         SDA_OE_N,
  input  wire [15:0] HUMID_RAW,
  input  wire [15:0] TEMP_RAW,
  output reg         MEAS_START,
  output reg         MEAS_TEMP,
  output reg         HEATER_ON
);

  // ----------------------------------------------------------------
  // Reset words
  // ----------------------------------------------------------------
  localparam [7:0] RST_STATE_WORD = `RST_CONV_STATE;
  localparam [7:0] RST_CTRL_WORD  = `RST_MEASURE_CTRL;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [5:0] ST_IDLE    = 6'b000001;
  localparam [5:0] ST_ADDR    = 6'b000010;
  localparam [5:0] ST_RX      = 6'b000100;
  localparam [5:0] ST_ACK_OUT = 6'b001000;
  localparam [5:0] ST_TX      = 6'b010000;
  localparam [5:0] ST_ACK_IN  = 6'b100000;

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg  [5:0] state;
  reg  [2:0] bit_cnt;
  reg  [7:0] rx_shift;
  reg  [7:0] tx_shift;
  reg        byte_done;
  reg        is_read;
  reg        have_ptr;
  reg        host_nack;
  reg  [7:0] ptr;
  reg        scl_q;
  reg        sda_q;

  reg  [7:0] result_high_byte;
  reg  [7:0] result_low_byte;
  reg        fast_mode;
  reg        temp_select;
  reg        not_ready;
  reg        conv_active;
  reg        update_done;

  wire       timer_done;
  wire [7:0] next_tx;

  wire scl_rise  = SCL & ~scl_q;
  wire scl_fall  = ~SCL & scl_q;
  wire bus_start = SCL & scl_q & sda_q & ~SDA_IN;
  wire bus_stop  = SCL & scl_q & ~sda_q & SDA_IN;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  // Reserved bits read as zero; host must not rely on that
  function [7:0] read_reg;
    input [7:0] addr;
    input       nrdy;
    input [7:0] hi;
    input [7:0] lo;
    input       fst;
    input       tmp;
    input       heater_on;
    input       busy;
    begin
      case (addr)
        `OFS_CONV_STATE:   read_reg = {7'h00, nrdy};
        `OFS_RESULT_HIGH:  read_reg = hi;
        `OFS_RESULT_LOW:   read_reg = lo;
        `OFS_MEASURE_CTRL: read_reg = {2'b00, fst, tmp, 2'b00, heater_on, busy};
        `OFS_PART_ID:      read_reg = {PART_CODE, 4'h0};
        default:           read_reg = 8'h00;
      endcase
    end
  endfunction

  assign next_tx = read_reg(ptr, not_ready, result_high_byte, result_low_byte,
                            fast_mode, temp_select, HEATER_ON, conv_active);

  // ----------------------------------------------------------------
  // Conversion timer
  // ----------------------------------------------------------------
  conv_timer #(
    .NORMAL_CYCLES (CONV_NORMAL_CYCLES),
    .FAST_CYCLES   (CONV_FAST_CYCLES)
  ) u_conv_timer (
    .clk     (CLK),
    .reset_n (RESET_N),
    .start   (MEAS_START),
    .fast    (fast_mode),
    .done    (timer_done)
  );

  // ----------------------------------------------------------------
  // Bus line history
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (!RESET_N) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= SCL;
      sda_q <= SDA_IN;
    end
  end

  // ----------------------------------------------------------------
  // Conversion result and ready flag
  // ----------------------------------------------------------------
  // The flag drops one cycle after the data registers load, so a
  // host that sees ready never reads a half-updated result.
  always @(posedge CLK) begin
    if (!RESET_N) begin
      result_high_byte <= `RST_RESULT_HIGH;
      result_low_byte  <= `RST_RESULT_LOW;
      update_done      <= 1'b0;
    end else begin
      update_done <= 1'b0;
      if (timer_done) begin
        if (MEAS_TEMP) begin
          result_high_byte <= TEMP_RAW[15:8];
          result_low_byte  <= TEMP_RAW[7:0];
        end else begin
          result_high_byte <= HUMID_RAW[15:8];
          result_low_byte  <= HUMID_RAW[7:0];
        end
        update_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Bus target state machine and register writes
  // ----------------------------------------------------------------
  always @(posedge CLK) begin
    if (!RESET_N) begin
      state       <= ST_IDLE;
      bit_cnt     <= 3'h0;
      rx_shift    <= 8'h00;
      tx_shift    <= 8'h00;
      byte_done   <= 1'b0;
      is_read     <= 1'b0;
      have_ptr    <= 1'b0;
      host_nack   <= 1'b0;
      ptr         <= 8'h00;
      SDA_OUT     <= 1'b0;
      SDA_OE_N    <= 1'b1;
      MEAS_START  <= 1'b0;
      MEAS_TEMP   <= 1'b0;
      HEATER_ON   <= RST_CTRL_WORD[`BIT_HEATER_ON];
      fast_mode   <= 1'b0;
      temp_select <= 1'b0;
      not_ready   <= RST_STATE_WORD[`BIT_NOT_READY];
      conv_active <= 1'b0;
    end else begin
      MEAS_START <= 1'b0;
      if (update_done) begin
        not_ready   <= 1'b0;
        conv_active <= 1'b0;
      end
      if (bus_start) begin
        // A repeated start keeps the pointer for the read that follows
        state     <= ST_ADDR;
        bit_cnt   <= 3'h0;
        byte_done <= 1'b0;
        have_ptr  <= 1'b0;
        SDA_OE_N  <= 1'b1;
      end else if (bus_stop) begin
        state    <= ST_IDLE;
        have_ptr <= 1'b0;
        SDA_OE_N <= 1'b1;
      end else begin
        case (state)
          ST_IDLE: begin
            SDA_OE_N <= 1'b1;
          end
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              rx_shift <= {rx_shift[6:0], SDA_IN};
              bit_cnt  <= bit_cnt + 3'h1;
              if (bit_cnt == 3'h7) begin
                byte_done <= 1'b1;
              end
            end else if (scl_fall && byte_done) begin
              byte_done <= 1'b0;
              if (state == ST_ADDR) begin
                if (rx_shift[7:1] == `TARGET_ADDR) begin
                  is_read  <= rx_shift[0];
                  state    <= ST_ACK_OUT;
                  SDA_OE_N <= 1'b0;
                end else begin
                  state <= ST_IDLE;
                end
              end else begin
                state    <= ST_ACK_OUT;
                SDA_OE_N <= 1'b0;
                if (!have_ptr) begin
                  ptr      <= rx_shift;
                  have_ptr <= 1'b1;
                end else begin
                  ptr <= ptr + 8'h01;
                  // Only defined bits are stored; others are dropped
                  if (ptr == `OFS_MEASURE_CTRL) begin
                    fast_mode   <= rx_shift[`BIT_FAST];
                    temp_select <= rx_shift[`BIT_TEMP];
                    HEATER_ON   <= rx_shift[`BIT_HEATER_ON];
                    // A start during a running conversion is ignored
                    if (rx_shift[`BIT_START] && !conv_active) begin
                      MEAS_START  <= 1'b1;
                      MEAS_TEMP   <= rx_shift[`BIT_TEMP];
                      conv_active <= 1'b1;
                      not_ready   <= 1'b1;
                    end
                  end
                end
              end
            end
          end
          ST_ACK_OUT: begin
            if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (is_read) begin
                tx_shift <= next_tx;
                SDA_OE_N <= next_tx[7];
                state    <= ST_TX;
              end else begin
                SDA_OE_N <= 1'b1;
                state    <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt == 3'h7) begin
                SDA_OE_N <= 1'b1;
                ptr      <= ptr + 8'h01;
                state    <= ST_ACK_IN;
              end else begin
                bit_cnt  <= bit_cnt + 3'h1;
                SDA_OE_N <= tx_shift[6];
                tx_shift <= {tx_shift[6:0], 1'b0};
              end
            end
          end
          ST_ACK_IN: begin
            if (scl_rise) begin
              host_nack <= SDA_IN;
            end else if (scl_fall) begin
              if (host_nack) begin
                state <= ST_IDLE;
              end else begin
                bit_cnt  <= 3'h0;
                tx_shift <= next_tx;
                SDA_OE_N <= next_tx[7];
                state    <= ST_TX;
              end
            end
          end
          default: begin
            state    <= ST_IDLE;
            SDA_OE_N <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

// *** design/sensor_regs_consts.vh ***
// Constants for the humidity and temperature sensor register block
`ifndef SENSOR_REGS_CONSTS_VH
`define SENSOR_REGS_CONSTS_VH

// ----------------------------------------------------------------
// Bus target address and register offsets
// ----------------------------------------------------------------
`define TARGET_ADDR          7'h40
`define OFS_CONV_STATE       8'h00
`define OFS_RESULT_HIGH      8'h01
`define OFS_RESULT_LOW       8'h02
`define OFS_MEASURE_CTRL     8'h03
`define OFS_PART_ID          8'h11

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define BIT_NOT_READY        0
`define BIT_FAST             5
`define BIT_TEMP             4
`define BIT_HEATER_ON             1
`define BIT_START            0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_CONV_STATE       8'h01
`define RST_RESULT_HIGH      8'h00
`define RST_RESULT_LOW       8'h00
`define RST_MEASURE_CTRL     8'h00

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_KHZ              20000
`define CONV_NORMAL_MS       35
`define CONV_FAST_MS         18
// Cycle counts of the two conversion times at the 20 MHz clock, sized to the timer
`define CONV_NORMAL_CYCLES   20'd700000
`define CONV_FAST_CYCLES     20'd360000

`endif

// *** design/conv_timer.v ***
// Conversion duration timer, normal or fast
`timescale 1ns/1ns
module conv_timer #(
  parameter [19:0] NORMAL_CYCLES = 20'd700000,
  parameter [19:0] FAST_CYCLES   = 20'd360000
) (
  input  wire clk,
  input  wire reset_n,
  input  wire start,
  input  wire fast,
  output reg  done
);

  reg [19:0] count;
  reg        running;

  always @(posedge clk) begin
    if (!reset_n) begin
      count   <= 20'h00000;
      running <= 1'b0;
      done    <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count   <= fast ? FAST_CYCLES : NORMAL_CYCLES;
        running <= 1'b1;
      end else if (running) begin
        if (count <= 20'h00001) begin
          running <= 1'b0;
          done    <= 1'b1;
        end else begin
          count <= count - 20'h00001;
        end
      end
    end
  end

endmodule

// *** test/sensor_regs_assertions.sv ***
// Port checks for the sensor register block
`timescale 1ns/1ns
module sensor_regs_checker #(
  parameter [19:0] CONV_NORMAL_CYCLES = 20'd700000,
  parameter [19:0] CONV_FAST_CYCLES   = 20'd360000
) (
  input wire CLK,
  input wire RESET_N,
  input wire SCL,
  input wire SDA_OUT,
  input wire SDA_OE_N,
  input wire MEAS_START,
  input wire MEAS_TEMP,
  input wire HEATER_ON
);
  reg [19:0] since;
  reg        seen;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  // Cycles since the last launch; saturates so a long idle never wraps
  always @(posedge CLK) begin
    if (!RESET_N) begin
      since <= 20'h00000;
      seen  <= 1'b0;
    end else if (MEAS_START) begin
      since <= 20'h00000;
      seen  <= 1'b1;
    end else if (since != 20'hfffff) begin
      since <= since + 20'h00001;
    end
  end
  chk_start_pulse: assert property (MEAS_START |=> !MEAS_START)
    else $error("launch pulse longer than one cycle");
  chk_start_at_ack: assert property (MEAS_START |-> !SDA_OE_N && !SCL)
    else $error("launch not on the data acknowledge");
  chk_launch_gap: assert property (MEAS_START |-> !seen || since >= CONV_FAST_CYCLES)
    else $error("launch while a conversion runs");
  chk_drive_scl_low: assert property ($changed(SDA_OE_N) |-> !SCL && !$past(SCL))
    else $error("data line changed while bus clock high");
  chk_drive_low_only: assert property (!SDA_OUT)
    else $error("data line driven high");
  chk_temp_at_launch: assert property ($changed(MEAS_TEMP) |-> MEAS_START || $past(MEAS_START))
    else $error("quantity changed outside a launch");
  chk_temp_held: assert property (MEAS_START |-> ##2 $stable(MEAS_TEMP) [*8])
    else $error("quantity changed during a conversion");
  chk_heater_on_on_write: assert property ($changed(HEATER_ON) |-> !SCL)
    else $error("heater changed outside a register write");
  cover property (MEAS_START && MEAS_TEMP);
  cover property (MEAS_START && !MEAS_TEMP);
  cover property ($rose(HEATER_ON));
endmodule
bind humidity_temp_sensor_regs sensor_regs_checker #(
  .CONV_NORMAL_CYCLES(CONV_NORMAL_CYCLES),
  .CONV_FAST_CYCLES  (CONV_FAST_CYCLES)
) chk (
  .CLK       (CLK),
  .RESET_N   (RESET_N),
  .SCL       (SCL),
  .SDA_OUT   (SDA_OUT),
  .SDA_OE_N  (SDA_OE_N),
  .MEAS_START(MEAS_START),
  .MEAS_TEMP (MEAS_TEMP),
  .HEATER_ON (HEATER_ON)
);

// *** test/i2c_host.sv ***
// Host bus controller model driving the sensor register block
`timescale 1ns/1ns
module i2c_host (
  input  wire  clk,
  input  wire  sda,
  output logic scl,
  output logic sda_drv
);
  int nacks = 0;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  // Every change lands 2 ns after a rising edge; a phase lasts 4 cycles
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    tick(4);
    scl = 1'b1;
    tick(4);
    r = sda;
    scl = 1'b0;
    tick(4);
  endtask
  // Serves as both start and repeated start
  task automatic start();
    sda_drv = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_drv = 1'b0;
    tick(4);
    scl = 1'b0;
    tick(4);
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    tick(4);
    scl = 1'b1;
    tick(4);
    sda_drv = 1'b1;
    tick(4);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic last,
                         output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(last, ack);
  endtask
  task automatic send(input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    byte_io(d, 1'b1, q, a);
    nacks += (a !== 1'b0);
  endtask
  task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] val);
    start();
    send(8'h80);
    send(ofs);
    send(val);
    stop();
  endtask
  // Pointer write, restart, read; last byte answered with NACK
  task automatic reg_rd(input logic [7:0] ofs, input int n, output logic [15:0] v);
    logic a;
    v = 16'h0000;
    start();
    send(8'h80);
    send(ofs);
    start();
    send(8'h81);
    byte_io(8'hff, n == 1, v[7:0], a);
    if (n == 2) begin
      v[15:8] = v[7:0];
      byte_io(8'hff, 1'b1, v[7:0], a);
    end
    stop();
  endtask
endmodule

// *** test/tb_top.sv ***
// Self-checking bench for the sensor register block
`timescale 1ns/1ns
module tb_top;
  localparam int NORM = 3000;
  localparam int FAST = 1200;
  logic        CLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic [15:0] HUMID_RAW = 16'h0000;
  logic [15:0] TEMP_RAW = 16'h0000;
  wire         SCL, SDA_OUT, SDA_OE_N, MEAS_START, MEAS_TEMP, HEATER_ON, host_sda;
  // Pull-up wire: either party may pull it low
  wire         sda = host_sda & (SDA_OE_N | SDA_OUT);
  int          miscompares = 0, n_compared = 0, launches = 0, t_launch = 0, cyc = 0, n;
  logic [15:0] v;
  logic [7:0]  cfg, q;
  logic        a;
  humidity_temp_sensor_regs #(
    .CONV_NORMAL_CYCLES(20'd3000),
    .CONV_FAST_CYCLES  (20'd1200),
    .PART_CODE         (4'h9)
  ) uut (
    .CLK(CLK), .RESET_N(RESET_N), .SCL(SCL), .SDA_IN(sda), .SDA_OUT(SDA_OUT),
    .SDA_OE_N(SDA_OE_N), .HUMID_RAW(HUMID_RAW), .TEMP_RAW(TEMP_RAW),
    .MEAS_START(MEAS_START), .MEAS_TEMP(MEAS_TEMP), .HEATER_ON(HEATER_ON)
  );
  i2c_host host (.clk(CLK), .sda(sda), .scl(SCL), .sda_drv(host_sda));
  initial forever #25 CLK = ~CLK;
  // Sampled on the falling edge, clear of the launch edge
  always @(negedge CLK) begin
    cyc++;
    if (MEAS_START === 1'b1) begin
      launches++;
      t_launch = cyc;
    end
  end
  function automatic logic [15:0] exp_result(input logic t);
    return t ? TEMP_RAW : HUMID_RAW;
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #3000000;
    miscompares++;
    conclude();
  end
  initial begin
    void'($urandom(32'h31b72c29));
    repeat (20) @(posedge CLK);
    #2 RESET_N = 1'b1;
    host.tick(4);
    host.reg_rd(8'h00, 1, v);
    check("status", v, 16'h0001);
    host.reg_rd(8'h01, 2, v);
    check("result", v, 16'h0000);
    host.reg_rd(8'h03, 1, v);
    check("control", v, 16'h0000);
    host.reg_rd(8'h11, 1, v);
    check("ident", v, 16'h0090);
    host.reg_rd(8'h07, 1, v);
    check("unmapped", v, 16'h0000);
    host.start();
    host.byte_io(8'h82, 1'b1, q, a);
    host.stop();
    check("foreign address ack", a, 1'b1);
    for (int i = 0; i < 4; i++) begin
      HUMID_RAW = $urandom;
      TEMP_RAW = $urandom;
      cfg = {2'b00, i[1], i[0], 2'b00, 1'($urandom_range(1, 0)), 1'b1};
      host.reg_wr(8'h03, cfg);
      check("heater", HEATER_ON, cfg[1]);
      check("quantity", MEAS_TEMP, cfg[4]);
      host.reg_rd(8'h00, 1, v);
      check("busy", v[0], 1'b1);
      host.reg_wr(8'h03, cfg);
      check("launches", 16'(launches), 16'(i + 1));
      n = 0;
      do host.reg_rd(8'h00, 1, v); while (v[0] !== 1'b0 && ++n < 20);
      n = cfg[5] ? FAST : NORM;
      check("duration", cyc - t_launch >= n && cyc - t_launch < n + 700, 1'b1);
      host.reg_rd(8'h01, 2, v);
      check("result", v, exp_result(cfg[4]));
      host.reg_rd(8'h03, 1, v);
      check("control", v, cfg & 8'h32);
    end
    // The host writes only defined locations; a read-only one ignores it
    host.reg_wr(8'h00, 8'h00);
    host.reg_rd(8'h03, 1, v);
    check("control kept", v, cfg & 8'h32);
    host.reg_rd(8'h00, 1, v);
    check("status kept", v, 16'h0000);
    check("host nacks", 16'(host.nacks), 16'h0000);
    conclude();
  end
endmodule
